/* File: core/dlp_dimmer.sv */
// dimming level pwm generator with fused settings and avalon status access
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "dlp_params.svh"
// What this block does and expects of its inputs
// R01: unfused default 5%, 1 khz, off-option disabled
// R02: minimum duty fuse selects 1,2,5,10 percent
// R03: frequency fuse selects 200,500,1k,2k hz
// R04: below 1 v minimum duty, or off
// R05: 1 to 9 v ramps min to 100%
// R06: above 9 v output always high
// R07: minimum entry level is 1v plus min*8v
// R08: transparent mode copies sense input to output
// R09: transparent needs off fuse and 2 khz
// R10: external pulses at least 2.6 us wide
// R11: fuse receive pin tied low in operation
// R12: digitized level, cycle-counted period and high time
// R13: fuses latched after reset, then constant
module dlp_dimmer #(
    parameter int LW = 12,   // adc code width
    parameter int CW = 17    // counter width, fits 100000 cycles at 200 hz
) (
    input  wire logic          core_clk,          // system clock
    input  wire logic          sys_rst,           // synchronous reset
    input  wire logic [LW-1:0] level_code,        // digitized sense voltage, full scale 10 v
    input  wire logic          sense_pwm_level,   // sense input as logic level for transparent use
    input  wire logic [1:0]    min_duty_fuse,     // fused minimum duty select
    input  wire logic [1:0]    pwm_freq_fuse,     // fused frequency select
    input  wire logic          off_at_low_level_fuse, // fused off-at-low-level bit
    input  wire logic          fuse_rx,           // fuse programming receive, only read back in the status register
    input  wire logic [3:0]    avs_address,       // avalon byte address
    input  wire logic          avs_read,          // avalon read
    input  wire logic          avs_write,         // avalon write
    input  wire logic [31:0]   avs_writedata,     // avalon write data
    output logic [31:0]        avs_readdata,      // avalon read data
    output logic               avs_waitrequest,   // avalon wait
    output logic               pwm_current_output // drive toward opto-coupler
);
    dlp_pkg::dlp_min_e  min_reg;     // latched settings
    dlp_pkg::dlp_frq_e  frq_reg;
    logic               off_reg;
    logic               latched_reg; // fuses sampled once after reset
    logic               ack_reg;     // one wait cycle per access
    logic [31:0]        rdata_reg;
    logic [LW-1:0]      level_reg;   // registered level
    logic               out_reg;
    logic               transp;
    logic [CW-1:0]      period;
    logic [CW-1:0]      high_time;
    logic [CW-1:0]      min_high;
    logic [CW-1:0]      lin_high;
    logic [LW-1:0]      lo_code;
    logic [LW-1:0]      hi_code;
    logic [LW-1:0]      entry_code;
    dlp_pkg::dlp_zone_e zone;
    logic               pwm_raw;
    logic [31:0]        rd_mux;

    // convert millivolts to adc code
    function automatic logic [LW-1:0] mv_to_code(input int mv);
        longint c;
        c = (longint'(mv) * ((longint'(1) << LW) - 1)) / `DLP_FULL_MV;
        return LW'(c);
    endfunction

    // percent value of the minimum duty select
    function automatic int min_pct(input dlp_pkg::dlp_min_e m);
        int p;
        p = `DLP_MIN5_PCT;
        unique case (m)
            dlp_pkg::DLP_MIN_1:  p = `DLP_MIN1_PCT;
            dlp_pkg::DLP_MIN_2:  p = `DLP_MIN2_PCT;
            dlp_pkg::DLP_MIN_5:  p = `DLP_MIN5_PCT;
            dlp_pkg::DLP_MIN_10: p = `DLP_MIN10_PCT;
        endcase
        return p;
    endfunction

    // period in clock cycles per frequency select
    function automatic logic [CW-1:0] per_cycles(input dlp_pkg::dlp_frq_e f);
        int hz;
        hz = `DLP_F1K_HZ;
        unique case (f)
            dlp_pkg::DLP_F_200: hz = `DLP_F200_HZ;
            dlp_pkg::DLP_F_500: hz = `DLP_F500_HZ;
            dlp_pkg::DLP_F_1K:  hz = `DLP_F1K_HZ;
            dlp_pkg::DLP_F_2K:  hz = `DLP_F2K_HZ;
        endcase
        return CW'(`DLP_CLK_HZ / hz);
    endfunction

    assign lo_code = mv_to_code(`DLP_LO_MV);
    assign hi_code = mv_to_code(`DLP_HI_MV);
    // entry level: 1 v plus min fraction of the 8 v span
    assign entry_code = mv_to_code(`DLP_LO_MV + (min_pct(min_reg) * `DLP_SPAN_MV) / 100); // R07

    assign period   = per_cycles(frq_reg); // R03
    assign min_high = CW'((32'(period) * 32'(min_pct(min_reg))) / 100); // R02
    // linear ramp, 0 % at 1 v to 100 % at 9 v; clamped below by min_high
    assign lin_high = CW'((64'(period) * 64'(level_reg - lo_code)) / 64'(hi_code - lo_code)); // R05

    // zone of the sensed level
    assign zone = (level_reg > hi_code) ? dlp_pkg::DLP_ST_FULL :
                  (level_reg < lo_code) ? (off_reg ? dlp_pkg::DLP_ST_OFF : dlp_pkg::DLP_ST_MIN) :
                  (level_reg < entry_code) ? dlp_pkg::DLP_ST_MIN : dlp_pkg::DLP_ST_LIN;

    // off zone gives zero high time, full gives whole period
    assign high_time = (zone == dlp_pkg::DLP_ST_OFF)  ? '0 :              // R04
                       (zone == dlp_pkg::DLP_ST_FULL) ? period :          // R06
                       (zone == dlp_pkg::DLP_ST_MIN)  ? min_high :        // R04
                       ((lin_high < min_high) ? min_high : lin_high);     // R05

    // transparent only with off fuse high and 2 khz; min duty ignored
    assign transp = off_reg && (frq_reg == dlp_pkg::DLP_F_2K); // R09

    dlp_pwm_counter #(.CW(CW)) u_cnt (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .period     (period),
        .high_time  (high_time),
        .pwm_out    (pwm_raw),
        .period_end ()
    );

    // fuse latch after reset; settings stay fixed afterwards
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            min_reg     <= dlp_pkg::dlp_min_e'(`DLP_MIN_RST); // R01
            frq_reg     <= dlp_pkg::dlp_frq_e'(`DLP_FRQ_RST); // R01
            off_reg     <= `DLP_OFF_RST;                      // R01
            latched_reg <= 1'b0;
        end
        else if (!latched_reg)
        begin
            min_reg     <= dlp_pkg::dlp_min_e'(min_duty_fuse); // R13
            frq_reg     <= dlp_pkg::dlp_frq_e'(pwm_freq_fuse); // R13
            off_reg     <= off_at_low_level_fuse;              // R13
            latched_reg <= 1'b1;
        end
    end

    // level sample and output select
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            level_reg <= '0;
            out_reg   <= 1'b0;
        end
        else
        begin
            level_reg <= level_code;                              // R12
            out_reg   <= transp ? sense_pwm_level : pwm_raw;      // R08
        end
    end
    assign pwm_current_output = out_reg;

    // read mux: config, status, level; writes ignored since settings are fused
    assign rd_mux = (avs_address == `DLP_CFG_OFS)   ? {27'h0, off_reg, frq_reg, min_reg} :
                    (avs_address == `DLP_STAT_OFS)  ? {26'h0, fuse_rx, latched_reg, transp, zone, out_reg} :
                    (avs_address == `DLP_LEVEL_OFS) ? 32'(level_reg) : 32'h0;

    // avalon slave: every access waits one cycle, then completes
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
            if (avs_read && !ack_reg)
                rdata_reg <= rd_mux;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign avs_readdata    = rdata_reg;
endmodule

/* File: include/dlp_params.svh */
// constants for the dimming level pwm generator
`ifndef DLP_PARAMS_SVH
`define DLP_PARAMS_SVH
// clock rate
`define DLP_CLK_HZ          20000000
// pwm frequencies in hz
`define DLP_F200_HZ         200
`define DLP_F500_HZ         500
`define DLP_F1K_HZ          1000
`define DLP_F2K_HZ          2000
// minimum duty cycle in percent
`define DLP_MIN1_PCT        1
`define DLP_MIN2_PCT        2
`define DLP_MIN5_PCT        5
`define DLP_MIN10_PCT       10
// sensed level thresholds in millivolts and the linear span
`define DLP_LO_MV           1000
`define DLP_HI_MV           9000
`define DLP_SPAN_MV         8000
// adc full scale in millivolts
`define DLP_FULL_MV         10000
// avalon offsets
`define DLP_CFG_OFS         4'h0
`define DLP_STAT_OFS        4'h4
`define DLP_LEVEL_OFS       4'h8
// config field positions
`define DLP_CFG_MIN_LSB     0
`define DLP_CFG_FRQ_LSB     2
`define DLP_CFG_OFF_BIT     4
// fuse reset values: 5 %, 1 khz, off-at-low-level disabled
`define DLP_MIN_RST         2'h2
`define DLP_FRQ_RST         2'h2
`define DLP_OFF_RST         1'h0
`endif

/* File: include/dlp_pkg.sv */
// types for the dimming level pwm generator
package dlp_pkg;
    typedef enum logic [1:0] {DLP_MIN_1, DLP_MIN_2, DLP_MIN_5, DLP_MIN_10} dlp_min_e;
    typedef enum logic [1:0] {DLP_F_200, DLP_F_500, DLP_F_1K, DLP_F_2K} dlp_frq_e;
    typedef enum logic [1:0] {DLP_ST_OFF, DLP_ST_MIN, DLP_ST_LIN, DLP_ST_FULL} dlp_zone_e;
endpackage

/* File: core/dlp_pwm_counter.sv */
// period and high-time counter that emits the pwm level
`timescale 1ns/10ps
module dlp_pwm_counter #(
    parameter int CW = 17
) (
    input  wire logic          core_clk,   // system clock
    input  wire logic          sys_rst,    // synchronous reset
    input  wire logic [CW-1:0] period,     // cycles per pwm period
    input  wire logic [CW-1:0] high_time,  // high cycles per period
    output logic               pwm_out,    // registered pwm level
    output logic               period_end  // pulse on last cycle of a period
);
    logic [CW-1:0] cnt_reg;   // position inside period
    logic [CW-1:0] cnt_next;
    logic [CW-1:0] hi_reg;    // high time held for a whole period to avoid glitches
    logic          wrap;

    assign wrap       = (cnt_reg >= period - CW'(1));
    assign cnt_next   = wrap ? '0 : cnt_reg + CW'(1);
    assign period_end = wrap;

    // period counter; high time is sampled only at a period boundary
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cnt_reg <= '0;
            hi_reg  <= '0;
            pwm_out <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;           // R12
            if (wrap)
                hi_reg <= high_time;
            pwm_out <= (cnt_next < (wrap ? high_time : hi_reg)); // R12
        end
    end
endmodule

/* File: sim/dlp_dimmer_monitor.sv */
// port checker for the dimming pwm generator
`timescale 1ns/10ps
module dlp_dimmer_monitor #(parameter int LW = 12) (
    input wire logic          core_clk,
    input wire logic          sys_rst,
    input wire logic [LW-1:0] level_code,
    input wire logic          sense_pwm_level,
    input wire logic [1:0]    pwm_freq_fuse,
    input wire logic          off_at_low_level_fuse,
    input wire logic          avs_read,
    input wire logic          avs_waitrequest,
    input wire logic [31:0]   avs_readdata,
    input wire logic          pwm_current_output
);
    logic [16:0] stb_reg, hi_reg; // steady level cycles, high pulse cycles
    logic [1:0]  run_reg;         // edges since reset release
    wire trn = off_at_low_level_fuse && pwm_freq_fuse == 2'h3;
    // one fused period plus pipeline slack, 500 hz taking the 200 hz limit; slow settings need far longer before a boundary is sure
    wire [16:0] lim = (pwm_freq_fuse == 2'h3) ? 17'd10010 : (pwm_freq_fuse == 2'h2) ? 17'd20010 : 17'd100010;
    wire calm = stb_reg > lim && !trn; // a period boundary has surely passed
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge core_clk) run_reg <= sys_rst ? 2'h0 : {run_reg[0], 1'b1};
    // saturates so a long steady level never wraps back below the limit
    always_ff @(posedge core_clk) stb_reg <= sys_rst || $changed(level_code) ? 17'h0 : stb_reg + 17'(stb_reg != 17'h1ffff);
    always_ff @(posedge core_clk) hi_reg <= pwm_current_output ? hi_reg + 17'h1 : 17'h0;
    a_rst_out_low: assert property (disable iff (1'b0) sys_rst |=> !pwm_current_output)
        else $error("out high");
    a_wait_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    a_wait_first: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("no wait");
    a_read_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata)) else $error("moved");
    a_transp_copy: assert property (run_reg[1] && trn |-> pwm_current_output == $past(sense_pwm_level))
        else $error("no copy");
    a_full_high: assert property (calm && level_code > 3685 |-> pwm_current_output) else $error("not full");
    a_off_low: assert property (calm && off_at_low_level_fuse && level_code < 409 |-> !pwm_current_output)
        else $error("not off");
    a_min_pulse: assert property (calm && !off_at_low_level_fuse && $fell(pwm_current_output) |-> hi_reg > 98)
        else $error("short");
    c_copy: cover property (trn && $rose(pwm_current_output));
    c_full: cover property (calm && pwm_current_output && level_code > 3685);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind dlp_dimmer dlp_dimmer_monitor #(.LW(LW)) dlp_dimmer_monitor_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .level_code(level_code), .sense_pwm_level(sense_pwm_level), .pwm_freq_fuse(pwm_freq_fuse),
    .off_at_low_level_fuse(off_at_low_level_fuse), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .pwm_current_output(pwm_current_output));

/* File: sim/dlp_sense_source.sv */
// far side: dimmer level code and external pwm on the sense pin, 3 us pulses
`timescale 1ns/10ps
module dlp_sense_source #(parameter int HALF = 60) (
    input wire logic        core_clk,
    input wire logic [11:0] level_req,
    input wire logic        pulse_en,
    output logic [11:0]     level_code = 0,
    output logic            sense_pwm_level = 0,
    output logic            fuse_rx
);
    int cnt = 0; // half period count
    assign fuse_rx = 1'b0;
    always @(posedge core_clk)
    begin
        level_code <= level_req;
        cnt <= (!pulse_en || cnt == HALF - 1) ? 0 : cnt + 1;
        sense_pwm_level <= pulse_en && (sense_pwm_level ^ (cnt == HALF - 1));
    end
endmodule

/* File: sim/test_dlp_dimmer.sv */
// bench for the dimming pwm generator
`timescale 1ns/10ps
`include "dlp_params.svh"
module test_dlp_dimmer;
    logic core_clk = 0, sys_rst = 1, rd_en = 0, wr_en = 0, pulse_en = 0, off_fuse = 0;
    logic sq[$]; // sense levels still in flight through the one-cycle output stage
    logic [1:0] mn = 2, fr = 2;
    logic [3:0] addr = 0;
    logic [11:0] lvl = 0, lvl_code;
    logic [31:0] wdata = 0, rdata, rd;
    logic wreq, pwm, sense, frx;
    int num_errors = 0, num_checks = 0, cyc = 0, hi, per, code, p = `DLP_CLK_HZ / `DLP_F2K_HZ;
    always #25 core_clk = ~core_clk;
    dlp_sense_source dlp_sense_source_inst (.core_clk(core_clk), .level_req(lvl), .pulse_en(pulse_en),
        .level_code(lvl_code), .sense_pwm_level(sense), .fuse_rx(frx));
    dlp_dimmer dlp_dimmer_inst (.core_clk(core_clk), .sys_rst(sys_rst), .level_code(lvl_code),
        .sense_pwm_level(sense), .min_duty_fuse(mn), .pwm_freq_fuse(fr), .off_at_low_level_fuse(off_fuse),
        .fuse_rx(frx), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
        .avs_readdata(rdata), .avs_waitrequest(wreq), .pwm_current_output(pwm));
    task automatic chk(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // fuses settle during an 8 cycle reset
    task automatic boot(input logic [1:0] m, f, input logic o);
        {mn, fr, off_fuse, sys_rst} <= {m, f, o, 1'b1};
        repeat (8) @(posedge core_clk);
        sys_rst <= 0;
        repeat (2) @(posedge core_clk);
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [3:0] a);
        {addr, wr_en, rd_en} <= {a, w, !w};
        @(posedge core_clk);
        while (wreq !== 1'b0)
            @(posedge core_clk);
        rd = rdata;
        {rd_en, wr_en} <= 0;
        @(posedge core_clk);
    endtask
    // high time and period of one output pulse, in cycles
    task automatic meas();
        time t;
        @(posedge pwm);
        t = $time;
        @(negedge pwm);
        hi = ($time - t) / 50;
        @(posedge pwm);
        per = ($time - t) / 50;
    endtask
    initial
    begin
        void'($urandom(32'hbfd9));
        for (int i = 0; i < 4; i++)
        begin
            boot(i[1:0], i[1:0], 0);
            mn <= ~mn;
            wdata <= $urandom();
            acc(1, 0);
            acc(0, 0);
            chk(rd, i * 5);
        end
        acc(0, 12);
        chk(rd, 0);
        // top code kept below full scale so the pulse always has a falling edge to time
        code = 409 + $urandom % 3276;
        lvl <= code;
        boot(1, 3, 0);
        meas();
        chk(per, p);
        chk(hi, p * (code - 409) / 3276 > p / 50 ? p * (code - 409) / 3276 : p / 50);
        acc(0, 8);
        chk(rd, code);
        lvl <= 200;
        meas();
        chk(hi, p / 50);
        lvl <= 4000;
        repeat (12000) @(posedge core_clk);
        chk(pwm, 1);
        acc(0, 4);
        chk(rd, 32'h17);
        lvl <= 100;
        boot(3, 2, 1);
        repeat (22000) @(posedge core_clk);
        chk(pwm, 0);
        boot(0, 3, 1);
        acc(0, 4);
        chk(rd[5:1], 32'hc);
        pulse_en <= 1;
        sq.push_back(sense);
        repeat (400)
        begin
            @(posedge core_clk);
            chk(pwm, sq.pop_front());
            sq.push_back(sense);
        end
        complete_run();
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 100000)
        begin
            num_errors++;
            complete_run();
        end
    end
endmodule
